// ==== verilog/src_pkg.sv ====
// Constants and types shared by the serial ROM command controller.
// Assumes a 50 MHz system clock and a byte-wide three-wire serial ROM
// with seven address bits.
package src_pkg;

  localparam int unsigned CLK_MHZ = 50;

  // Register byte addresses on the register bus.
  localparam logic [7:0] CMD_OFS = 8'hB0;
  localparam logic [7:0] DATA_OFS = 8'hB4;
  localparam logic [7:0] INT_STS_OFS = 8'hB8;
  localparam logic [7:0] INT_MASK_OFS = 8'hBC;
  localparam logic [7:0] STA_LO_OFS = 8'hC0;
  localparam logic [7:0] STA_HI_OFS = 8'hC4;

  // Command register fields.
  localparam int CMD_PEND_BIT = 31;
  localparam int CMD_OP_MSB = 30;
  localparam int CMD_OP_LSB = 28;
  localparam int CMD_LOADED_BIT = 8;
  localparam int CMD_WEN_BIT = 7;
  localparam int ADDR_W = 7;
  localparam logic [6:0] CMD_ADDR_RST = 7'h00;
  localparam logic [7:0] DATA_RST = 8'h00;

  // Interrupt status and mask layout.
  localparam int IRQ_W = 3;
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_TIMEOUT_BIT = 1;
  localparam int IRQ_FAIL_BIT = 2;
  localparam logic [2:0] IRQ_RST = 3'h0;

  typedef enum logic [2:0] {
    read_op = 3'h0,
    write_protect_on_op = 3'h1,
    write_protect_off_op = 3'h2,
    write_op = 3'h3,
    fill_all_op = 3'h4,
    erase_op = 3'h5,
    bulk_clear_op = 3'h6,
    reload_op = 3'h7
  } src_op_t;

  // Serial frame: start bit, two opcode bits, address, data.
  localparam int FRAME_W = 18;
  localparam logic [4:0] FRAME_BITS = 5'd18;
  localparam logic [4:0] HDR_BITS = 5'd10;
  localparam logic [1:0] SER_EXT = 2'h0;
  localparam logic [1:0] SER_WRITE = 2'h1;
  localparam logic [1:0] SER_READ = 2'h2;
  localparam logic [1:0] SER_ERASE = 2'h3;
  localparam logic [1:0] EXT_PROT_ON = 2'h0;
  localparam logic [1:0] EXT_FILL = 2'h1;
  localparam logic [1:0] EXT_CLEAR = 2'h2;
  localparam logic [1:0] EXT_PROT_OFF = 2'h3;

  localparam logic [7:0] STATION_SIG = 8'hA5;
  localparam logic [2:0] STATION_BYTES = 3'h6;
  localparam logic [47:0] STATION_RST = 48'h0;

  // Timing: serial clock half period, chip select gap, operation timeout.
  localparam int unsigned SK_HALF_NS = 500;
  localparam int unsigned SK_HALF_CYCLES = (SK_HALF_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned GAP_NS = 1000;
  localparam int unsigned GAP_CYCLES = (GAP_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned TIMEOUT_US = 30000;
  localparam int unsigned TIMEOUT_CYCLES = TIMEOUT_US * CLK_MHZ;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_SEND = 3'h1,
    ST_SHIFT = 3'h3,
    ST_GAP = 3'h2,
    ST_POLL = 3'h6,
    ST_FINISH = 3'h7
  } src_state_t;

endpackage : src_pkg

// ==== verilog/src_shifter.sv ====
// Bit engine that clocks one serial frame out to the ROM, MSB first.
// Assumes the data-in line is already synchronised to the system clock.
module src_shifter #(
  parameter int unsigned HALF_CYCLES = src_pkg::SK_HALF_CYCLES
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic start_in,
  input wire logic abort_in,
  input wire logic [17:0] frame_in,
  input wire logic [4:0] nbits_in,
  input wire logic di_in,
  output logic busy_out,
  output logic done_out,
  output logic sk_out,
  output logic do_out,
  output logic [7:0] rx_out
);

  logic [17:0] shreg;
  logic [4:0] left;
  logic [15:0] div;
  logic wrap;

  assign wrap = (div == 16'(HALF_CYCLES - 1));
  assign do_out = busy_out & shreg[17];

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      busy_out <= 1'b0;
      done_out <= 1'b0;
      sk_out <= 1'b0;
      shreg <= 18'h00000;
      left <= 5'h00;
      div <= 16'h0000;
      rx_out <= 8'h00;
    end else begin
      done_out <= 1'b0;
      if (abort_in) begin
        busy_out <= 1'b0;
        sk_out <= 1'b0;
      end else if (start_in && !busy_out) begin
        busy_out <= 1'b1;
        shreg <= frame_in;
        left <= nbits_in;
        div <= 16'h0000;
        sk_out <= 1'b0;
      end else if (busy_out) begin
        div <= wrap ? 16'h0000 : div + 16'h0001;
        if (wrap && !sk_out) begin
          // The ROM updates its output on the falling edge, so sample on the rise.
          sk_out <= 1'b1;
          rx_out <= {rx_out[6:0], di_in};
        end else if (wrap) begin
          sk_out <= 1'b0;
          shreg <= {shreg[16:0], 1'b0};
          left <= left - 5'h01;
          if (left == 5'h01) begin
            busy_out <= 1'b0;
            done_out <= 1'b1;
          end
        end
      end
    end
  end

endmodule : src_shifter

// ==== verilog/src_rom_ctrl.sv ====
// Serial ROM command controller with an AXI4-Lite register slave.
// Assumes one 50 MHz clock and a three-wire serial ROM on the pins.
module src_rom_ctrl #(
  parameter int unsigned TIMEOUT_CYCLES = src_pkg::TIMEOUT_CYCLES,
  parameter int unsigned SK_HALF = src_pkg::SK_HALF_CYCLES,
  parameter int unsigned GAP = src_pkg::GAP_CYCLES
) (
  input wire logic SYS_CLK_IN,
  input wire logic RST_B_IN,
  input wire logic [7:0] AXI_AWADDR_IN,
  input wire logic AXI_AWVALID_IN,
  output logic AXI_AWREADY_OUT,
  input wire logic [31:0] AXI_WDATA_IN,
  input wire logic [3:0] AXI_WSTRB_IN,
  input wire logic AXI_WVALID_IN,
  output logic AXI_WREADY_OUT,
  output logic [1:0] AXI_BRESP_OUT,
  output logic AXI_BVALID_OUT,
  input wire logic AXI_BREADY_IN,
  input wire logic [7:0] AXI_ARADDR_IN,
  input wire logic AXI_ARVALID_IN,
  output logic AXI_ARREADY_OUT,
  output logic [31:0] AXI_RDATA_OUT,
  output logic [1:0] AXI_RRESP_OUT,
  output logic AXI_RVALID_OUT,
  input wire logic AXI_RREADY_IN,
  output logic ROM_CS_OUT,
  output logic ROM_SK_OUT,
  output logic ROM_DO_OUT,
  input wire logic ROM_DI_IN,
  output logic [47:0] STATION_ADDR_OUT,
  output logic STATION_VALID_OUT,
  output logic IRQ_OUT
);

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  function automatic logic mapped(input logic [7:0] a);
    return (a == src_pkg::CMD_OFS) || (a == src_pkg::DATA_OFS) ||
           (a == src_pkg::INT_STS_OFS) || (a == src_pkg::INT_MASK_OFS) ||
           (a == src_pkg::STA_LO_OFS) || (a == src_pkg::STA_HI_OFS);
  endfunction : mapped

  function automatic logic [17:0] frame_of(input src_pkg::src_op_t op, input logic [6:0] a,
                                           input logic [7:0] d);
    logic [17:0] f;
    f = 18'h00000;
    unique case (op)
      src_pkg::read_op, src_pkg::reload_op: f = {1'b1, src_pkg::SER_READ, a, 8'h00};
      src_pkg::write_op: f = {1'b1, src_pkg::SER_WRITE, a, d};
      src_pkg::erase_op: f = {1'b1, src_pkg::SER_ERASE, a, 8'h00};
      src_pkg::write_protect_on_op: f = {1'b1, src_pkg::SER_EXT, src_pkg::EXT_PROT_ON,
                                         5'h00, 8'h00};
      src_pkg::write_protect_off_op: f = {1'b1, src_pkg::SER_EXT, src_pkg::EXT_PROT_OFF,
                                          5'h00, 8'h00};
      src_pkg::fill_all_op: f = {1'b1, src_pkg::SER_EXT, src_pkg::EXT_FILL, 5'h00, d};
      src_pkg::bulk_clear_op: f = {1'b1, src_pkg::SER_EXT, src_pkg::EXT_CLEAR,
                                   5'h00, 8'h00};
    endcase
    return f;
  endfunction : frame_of

  function automatic logic [4:0] len_of(input src_pkg::src_op_t op);
    logic long_frame;
    long_frame = (op == src_pkg::read_op) || (op == src_pkg::reload_op) ||
                 (op == src_pkg::write_op) || (op == src_pkg::fill_all_op);
    return long_frame ? src_pkg::FRAME_BITS : src_pkg::HDR_BITS;
  endfunction : len_of

  // Register bus state.
  logic aw_full;
  logic w_full;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_fire;
  logic [31:0] rd_word;

  // Registers and controller state.
  logic pending;
  src_pkg::src_op_t cmd_op;
  logic [6:0] cmd_addr;
  logic [7:0] data_reg;
  logic [2:0] irq_sts;
  logic [2:0] irq_mask;
  logic [2:0] irq_set;
  logic wen_shadow;
  logic [47:0] station;
  logic station_ok;
  src_pkg::src_state_t state;
  src_pkg::src_op_t cur_op;
  logic reload_req;
  logic [2:0] idx;
  logic [15:0] gap_cnt;
  logic gap_to_poll;
  logic [31:0] tmo_cnt;
  logic tmo_hit;
  logic sh_start;
  logic [17:0] sh_frame;
  logic [4:0] sh_len;
  logic sh_busy;
  logic sh_done;
  logic [7:0] sh_rx;
  logic di_meta;
  logic di_sync;
  logic host_cmd_wr;
  logic host_data_wr;
  logic [31:0] cmd_word;
  logic [31:0] cmd_new;

  assign wr_fire = aw_full & w_full & ~AXI_BVALID_OUT;
  assign AXI_AWREADY_OUT = ~aw_full;
  assign AXI_WREADY_OUT = ~w_full;
  assign AXI_ARREADY_OUT = ~AXI_RVALID_OUT;

  always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      AXI_BVALID_OUT <= 1'b0;
      AXI_BRESP_OUT <= src_pkg::RESP_OKAY;
    end else begin
      if (AXI_AWVALID_IN && !aw_full) begin
        aw_full <= 1'b1;
        aw_addr <= AXI_AWADDR_IN;
      end
      if (AXI_WVALID_IN && !w_full) begin
        w_full <= 1'b1;
        w_data <= AXI_WDATA_IN;
        w_strb <= AXI_WSTRB_IN;
      end
      if (wr_fire) begin
        aw_full <= 1'b0;
        w_full <= 1'b0;
        AXI_BVALID_OUT <= 1'b1;
        AXI_BRESP_OUT <= mapped(aw_addr) ? src_pkg::RESP_OKAY : src_pkg::RESP_SLVERR;
      end else if (AXI_BVALID_OUT && AXI_BREADY_IN) begin
        AXI_BVALID_OUT <= 1'b0;
      end
    end
  end

  assign cmd_word = {pending, cmd_op, 19'h00000, station_ok, wen_shadow, cmd_addr};
  assign cmd_new = merge({1'b0, cmd_word[30:0]}, w_data, w_strb);
  // host keeps off: command and data writes during a pending operation are dropped.
  assign host_cmd_wr = wr_fire && (aw_addr == src_pkg::CMD_OFS) && !pending;
  assign host_data_wr = wr_fire && (aw_addr == src_pkg::DATA_OFS) && !pending;

  always_comb begin
    rd_word = 32'h00000000;
    unique case (AXI_ARADDR_IN)
      src_pkg::CMD_OFS: rd_word = cmd_word;
      src_pkg::DATA_OFS: rd_word = {24'h000000, data_reg};
      src_pkg::INT_STS_OFS: rd_word = {29'h00000000, irq_sts};
      src_pkg::INT_MASK_OFS: rd_word = {29'h00000000, irq_mask};
      src_pkg::STA_LO_OFS: rd_word = station[31:0];
      src_pkg::STA_HI_OFS: rd_word = {16'h0000, station[47:32]};
      default: rd_word = 32'h00000000;
    endcase
  end

  always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      AXI_RVALID_OUT <= 1'b0;
      AXI_RDATA_OUT <= 32'h00000000;
      AXI_RRESP_OUT <= src_pkg::RESP_OKAY;
    end else if (AXI_ARVALID_IN && !AXI_RVALID_OUT) begin
      AXI_RVALID_OUT <= 1'b1;
      AXI_RDATA_OUT <= rd_word;
      AXI_RRESP_OUT <= mapped(AXI_ARADDR_IN) ? src_pkg::RESP_OKAY : src_pkg::RESP_SLVERR;
    end else if (AXI_RVALID_OUT && AXI_RREADY_IN) begin
      AXI_RVALID_OUT <= 1'b0;
    end
  end

  // Command fields the host may change while no operation is pending.
  always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      cmd_op <= src_pkg::read_op;
      cmd_addr <= src_pkg::CMD_ADDR_RST;
    end else if (host_cmd_wr) begin
      cmd_op <= src_pkg::src_op_t'(cmd_new[src_pkg::CMD_OP_MSB:src_pkg::CMD_OP_LSB]);
      cmd_addr <= cmd_new[src_pkg::ADDR_W-1:0];
    end
  end

  // Interrupt status is sticky; a new event beats a same-cycle clear.
  always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      irq_sts <= src_pkg::IRQ_RST;
      irq_mask <= src_pkg::IRQ_RST;
      IRQ_OUT <= 1'b0;
    end else begin
      if (wr_fire && aw_addr == src_pkg::INT_STS_OFS && w_strb[0]) begin
        irq_sts <= (irq_sts & ~w_data[2:0]) | irq_set;
      end else begin
        irq_sts <= irq_sts | irq_set;
      end
      if (wr_fire && aw_addr == src_pkg::INT_MASK_OFS && w_strb[0]) begin
        irq_mask <= w_data[2:0];
      end
      IRQ_OUT <= |(irq_sts & irq_mask);
    end
  end

  // The data-in pin comes from outside and is synchronised first.
  always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      di_meta <= 1'b0;
      di_sync <= 1'b0;
    end else begin
      di_meta <= ROM_DI_IN;
      di_sync <= di_meta;
    end
  end

  assign tmo_hit = (state != src_pkg::ST_IDLE) && (state != src_pkg::ST_FINISH) &&
                   (tmo_cnt == TIMEOUT_CYCLES - 1);

  always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      tmo_cnt <= 32'h00000000;
    end else if (state == src_pkg::ST_IDLE || state == src_pkg::ST_FINISH) begin
      tmo_cnt <= 32'h00000000;
    end else begin
      tmo_cnt <= tmo_cnt + 32'h00000001;
    end
  end

  always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      pending <= 1'b1;
      reload_req <= 1'b1;
      state <= src_pkg::ST_IDLE;
      cur_op <= src_pkg::reload_op;
      idx <= 3'h0;
      gap_cnt <= 16'h0000;
      gap_to_poll <= 1'b0;
      data_reg <= src_pkg::DATA_RST;
      wen_shadow <= 1'b0;
      station <= src_pkg::STATION_RST;
      station_ok <= 1'b0;
      sh_start <= 1'b0;
      sh_frame <= 18'h00000;
      sh_len <= 5'h00;
      irq_set <= src_pkg::IRQ_RST;
    end else begin
      sh_start <= 1'b0;
      irq_set <= src_pkg::IRQ_RST;
      if (host_data_wr) begin
        data_reg <= w_strb[0] ? w_data[7:0] : data_reg;
      end
      if (host_cmd_wr && cmd_new[src_pkg::CMD_PEND_BIT]) begin
        pending <= 1'b1;
      end
      if (tmo_hit) begin
        state <= src_pkg::ST_FINISH;
        irq_set[src_pkg::IRQ_TIMEOUT_BIT] <= 1'b1;
        if (cur_op == src_pkg::reload_op) begin
          irq_set[src_pkg::IRQ_FAIL_BIT] <= 1'b1;
        end
      end else begin
        unique case (state)
          src_pkg::ST_IDLE: begin
            if (pending) begin
              cur_op <= reload_req ? src_pkg::reload_op : cmd_op;
              reload_req <= 1'b0;
              idx <= 3'h0;
              if (reload_req || cmd_op == src_pkg::reload_op) begin
                station_ok <= 1'b0;
              end
              state <= src_pkg::ST_SEND;
            end
          end
          src_pkg::ST_SEND: begin
            sh_frame <= frame_of(cur_op, (cur_op == src_pkg::reload_op) ? {4'h0, idx}
                                 : cmd_addr, data_reg);
            sh_len <= len_of(cur_op);
            sh_start <= 1'b1;
            state <= src_pkg::ST_SHIFT;
          end
          src_pkg::ST_SHIFT: begin
            if (sh_done) begin
              gap_cnt <= 16'h0000;
              unique case (cur_op)
                src_pkg::reload_op: begin
                  // reload ends on success or bad signature.
                  if (idx == 3'h0 && sh_rx != src_pkg::STATION_SIG) begin
                    irq_set[src_pkg::IRQ_FAIL_BIT] <= 1'b1;
                    state <= src_pkg::ST_FINISH;
                  end else begin
                    if (idx != 3'h0) begin
                      station <= {sh_rx, station[47:8]};
                    end
                    if (idx == src_pkg::STATION_BYTES) begin
                      station_ok <= 1'b1;
                      state <= src_pkg::ST_FINISH;
                    end else begin
                      idx <= idx + 3'h1;
                      gap_to_poll <= 1'b0;
                      state <= src_pkg::ST_GAP;
                    end
                  end
                end
                src_pkg::read_op: begin
                  data_reg <= sh_rx;
                  state <= src_pkg::ST_FINISH;
                end
                src_pkg::write_protect_on_op: begin
                  wen_shadow <= 1'b0;
                  state <= src_pkg::ST_FINISH;
                end
                src_pkg::write_protect_off_op: begin
                  wen_shadow <= 1'b1;
                  state <= src_pkg::ST_FINISH;
                end
                default: begin
                  // Programming ops wait for the ready level on data-in.
                  gap_to_poll <= 1'b1;
                  state <= src_pkg::ST_GAP;
                end
              endcase
            end
          end
          src_pkg::ST_GAP: begin
            if (gap_cnt == 16'(GAP - 1)) begin
              state <= gap_to_poll ? src_pkg::ST_POLL : src_pkg::ST_SEND;
            end else begin
              gap_cnt <= gap_cnt + 16'h0001;
            end
          end
          src_pkg::ST_POLL: begin
            if (di_sync) begin
              state <= src_pkg::ST_FINISH;
            end
          end
          src_pkg::ST_FINISH: begin
            pending <= 1'b0;
            irq_set[src_pkg::IRQ_DONE_BIT] <= 1'b1;
            state <= src_pkg::ST_IDLE;
          end
          default: state <= src_pkg::ST_IDLE;
        endcase
      end
    end
  end

  src_shifter #(
    .HALF_CYCLES(SK_HALF)
  ) u_shifter (
    .clk_in(SYS_CLK_IN),
    .rst_b_in(RST_B_IN),
    .start_in(sh_start),
    .abort_in(tmo_hit),
    .frame_in(sh_frame),
    .nbits_in(sh_len),
    .di_in(di_sync),
    .busy_out(sh_busy),
    .done_out(sh_done),
    .sk_out(ROM_SK_OUT),
    .do_out(ROM_DO_OUT),
    .rx_out(sh_rx)
  );

  assign ROM_CS_OUT = sh_busy | (state == src_pkg::ST_POLL);
  assign STATION_ADDR_OUT = station;
  assign STATION_VALID_OUT = station_ok;

endmodule : src_rom_ctrl

// ==== verif/src_rom_ctrl_checker.sv ====
// Concurrent checks on the controller's register bus and serial pins.
// Bound to src_rom_ctrl; sees only its ports, one clock domain.
module src_rom_ctrl_checker #(
  parameter int unsigned TIMEOUT_CYCLES = 10000
) (
  input wire logic SYS_CLK_IN,
  input wire logic RST_B_IN,
  input wire logic [7:0] AXI_AWADDR_IN,
  input wire logic AXI_AWVALID_IN,
  input wire logic AXI_AWREADY_OUT,
  input wire logic [31:0] AXI_WDATA_IN,
  input wire logic AXI_WVALID_IN,
  input wire logic AXI_WREADY_OUT,
  input wire logic [1:0] AXI_BRESP_OUT,
  input wire logic AXI_BVALID_OUT,
  input wire logic AXI_BREADY_IN,
  input wire logic AXI_ARVALID_IN,
  input wire logic AXI_ARREADY_OUT,
  input wire logic [1:0] AXI_RRESP_OUT,
  input wire logic AXI_RVALID_OUT,
  input wire logic AXI_RREADY_IN,
  input wire logic ROM_CS_OUT,
  input wire logic ROM_SK_OUT,
  input wire logic ROM_DO_OUT
);
  default clocking @(posedge SYS_CLK_IN); endclocking
  default disable iff (!RST_B_IN);
  logic aw_w;
  int unsigned cs_cnt;
  assign aw_w = AXI_AWVALID_IN && AXI_AWREADY_OUT && AXI_WVALID_IN && AXI_WREADY_OUT;
  // A select held longer than the timeout means the watchdog never fired.
  always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      cs_cnt <= 0;
    end else begin
      cs_cnt <= ROM_CS_OUT ? cs_cnt + 1 : 0;
    end
  end
  property p_bhold;
    AXI_BVALID_OUT && !AXI_BREADY_IN |=> AXI_BVALID_OUT && $stable(AXI_BRESP_OUT);
  endproperty
  a_bhold: assert property (p_bhold) else $error("write response dropped");
  property p_rhold;
    AXI_RVALID_OUT && !AXI_RREADY_IN |=> AXI_RVALID_OUT && $stable(AXI_RRESP_OUT);
  endproperty
  a_rhold: assert property (p_rhold) else $error("read response dropped");
  property p_wlat;
    aw_w |-> ##2 AXI_BVALID_OUT;
  endproperty
  a_wlat: assert property (p_wlat) else $error("write answer late");
  property p_rlat;
    AXI_ARVALID_IN && AXI_ARREADY_OUT |=> AXI_RVALID_OUT && !AXI_ARREADY_OUT;
  endproperty
  a_rlat: assert property (p_rlat) else $error("read answer late");
  property p_start;
    aw_w && AXI_AWADDR_IN == src_pkg::CMD_OFS && AXI_WDATA_IN[31] |-> ##[2:10] ROM_CS_OUT;
  endproperty
  a_start: assert property (p_start) else $error("command did not start");
  property p_boot;
    $rose(RST_B_IN) |-> ##[1:5] ROM_CS_OUT;
  endproperty
  a_boot: assert property (p_boot) else $error("no load after reset");
  property p_skhigh;
    $rose(ROM_SK_OUT) |-> (ROM_SK_OUT && ROM_CS_OUT) [*8];
  endproperty
  a_skhigh: assert property (p_skhigh) else $error("serial clock too short");
  property p_dostable;
    ROM_SK_OUT && $past(ROM_SK_OUT) |-> $stable(ROM_DO_OUT);
  endproperty
  a_dostable: assert property (p_dostable) else $error("data moved in clock high");
  property p_timeout;
    cs_cnt < TIMEOUT_CYCLES + 8;
  endproperty
  a_timeout: assert property (p_timeout) else $error("operation never timed out");
  c_start: cover property ($rose(ROM_CS_OUT));
  c_read: cover property (AXI_RVALID_OUT && AXI_RREADY_IN);
  c_long: cover property (cs_cnt == TIMEOUT_CYCLES / 2);
endmodule : src_rom_ctrl_checker

bind src_rom_ctrl src_rom_ctrl_checker #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_chk (
  .SYS_CLK_IN(SYS_CLK_IN), .RST_B_IN(RST_B_IN), .AXI_AWADDR_IN(AXI_AWADDR_IN),
  .AXI_AWVALID_IN(AXI_AWVALID_IN), .AXI_AWREADY_OUT(AXI_AWREADY_OUT),
  .AXI_WDATA_IN(AXI_WDATA_IN), .AXI_WVALID_IN(AXI_WVALID_IN),
  .AXI_WREADY_OUT(AXI_WREADY_OUT), .AXI_BRESP_OUT(AXI_BRESP_OUT),
  .AXI_BVALID_OUT(AXI_BVALID_OUT), .AXI_BREADY_IN(AXI_BREADY_IN),
  .AXI_ARVALID_IN(AXI_ARVALID_IN), .AXI_ARREADY_OUT(AXI_ARREADY_OUT),
  .AXI_RRESP_OUT(AXI_RRESP_OUT), .AXI_RVALID_OUT(AXI_RVALID_OUT),
  .AXI_RREADY_IN(AXI_RREADY_IN), .ROM_CS_OUT(ROM_CS_OUT), .ROM_SK_OUT(ROM_SK_OUT),
  .ROM_DO_OUT(ROM_DO_OUT));

// ==== verif/src_rom_model.sv ====
// Behavioural three-wire serial ROM of 128 bytes with write protect.
// A board pull-down holds the data line low whenever the ROM releases it.
module src_rom_model (
  input wire logic cs_in,
  input wire logic sk_in,
  input wire logic do_in,
  input wire logic present_in,
  output logic di_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [128];
  logic [17:0] sr = 18'h0;
  logic [9:0] hdr = 10'h0;
  logic [7:0] q = 8'h00;
  logic wen = 1'b0;
  logic busy = 1'b0;
  logic rdp = 1'b0;
  logic dbit = 1'b0;
  int n = 0;
  initial begin
    foreach (mem[i]) mem[i] = 8'(8'h10 + i);
    mem[0] = 8'hA5;
  end
  always @(posedge cs_in) begin
    n = 0;
    rdp = 1'b0;
  end
  always @(posedge sk_in) begin
    if (cs_in) begin
      sr = {sr[16:0], do_in};
      n++;
      if (n == 10 && sr[9:7] == 3'b110) begin
        rdp = 1'b1;
        q = mem[sr[6:0]];
      end
    end
  end
  always @(negedge sk_in) begin
    if (rdp) begin
      dbit = q[7];
      q = {q[6:0], 1'b0};
    end
  end
  // A programming frame acts when select falls and only after 10 or 18 bits, so other cut-short frames change nothing.
  always @(negedge cs_in) begin
    hdr = (n == 18) ? sr[17:8] : sr[9:0];
    if (present_in && (n == 10 || n == 18)) begin
      if (hdr[8:5] == 4'b0011) wen = 1'b1;
      if (hdr[8:5] == 4'b0000) wen = 1'b0;
      if (wen && hdr[8:7] != 2'b10 && hdr[8:5] != 4'b0011) begin
        busy <= 1'b1;
        busy <= #5000 1'b0;
        if (hdr[8:5] == 4'b0001) foreach (mem[i]) mem[i] = sr[7:0];
        if (hdr[8:5] == 4'b0010) foreach (mem[i]) mem[i] = 8'hFF;
        if (hdr[8:7] == 2'b01) mem[hdr[6:0]] = sr[7:0];
        if (hdr[8:7] == 2'b11) mem[hdr[6:0]] = 8'hFF;
      end
    end
  end
  assign di_out = present_in && cs_in && (rdp ? dbit : (n == 0 && !busy));
endmodule : src_rom_model

// ==== verif/src_rom_ctrl_test.sv ====
// Self-checking bench: register bus tasks drive the controller,
// a ROM model answers on the serial pins.
module src_rom_ctrl_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned TO = 10000;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic present = 1'b1;
  logic awready, wready, bvalid, arready, rvalid, cs, sk, dout, din, stav, irq;
  logic [1:0] bresp, rresp, rsp;
  logic [31:0] rdata, rdat;
  logic [47:0] sta;
  int miscompares = 0;
  int n_tests = 0;
  int cyc = 0;
  int t0;
  always #10 clk = ~clk;
  src_rom_ctrl #(.TIMEOUT_CYCLES(TO)) uut (.SYS_CLK_IN(clk), .RST_B_IN(rst_b),
    .AXI_AWADDR_IN(awaddr), .AXI_AWVALID_IN(awvalid), .AXI_AWREADY_OUT(awready),
    .AXI_WDATA_IN(wdata), .AXI_WSTRB_IN(4'hF), .AXI_WVALID_IN(wvalid),
    .AXI_WREADY_OUT(wready), .AXI_BRESP_OUT(bresp), .AXI_BVALID_OUT(bvalid),
    .AXI_BREADY_IN(bready), .AXI_ARADDR_IN(araddr), .AXI_ARVALID_IN(arvalid),
    .AXI_ARREADY_OUT(arready), .AXI_RDATA_OUT(rdata), .AXI_RRESP_OUT(rresp),
    .AXI_RVALID_OUT(rvalid), .AXI_RREADY_IN(rready), .ROM_CS_OUT(cs),
    .ROM_SK_OUT(sk), .ROM_DO_OUT(dout), .ROM_DI_IN(din),
    .STATION_ADDR_OUT(sta), .STATION_VALID_OUT(stav), .IRQ_OUT(irq));
  src_rom_model u_rom (.cs_in(cs), .sk_in(sk), .do_in(dout), .present_in(present),
    .di_out(din));
  task automatic conclude;
    if (miscompares == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : conclude
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // Readies are sampled at the falling edge, where they equal the next rising edge.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge clk);
      ta = awready;
      tw = wready;
      tb = bvalid;
      rsp = bresp;
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end while (!tb);
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    logic ta, tr;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge clk);
      ta = arready && arvalid;
      tr = rvalid;
      rdat = rdata;
      rsp = rresp;
      @(posedge clk);
      if (ta) arvalid <= 1'b0;
    end while (!tr);
    rready <= 1'b0;
  endtask : rd
  task automatic settle;
    do rd(src_pkg::CMD_OFS);
    while (rdat[31] !== 1'b0);
  endtask : settle
  task automatic op(input logic [2:0] c, input logic [6:0] a, input logic [7:0] d);
    wr(src_pkg::DATA_OFS, {24'h0, d});
    wr(src_pkg::CMD_OFS, {1'b1, c, 21'h0, a});
    settle();
  endtask : op
  task automatic rdop(input logic [6:0] a, input logic [7:0] e);
    op(3'h0, a, 8'h00);
    rd(src_pkg::DATA_OFS);
    chk("rom_byte", {24'h0, e}, rdat);
  endtask : rdop
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      miscompares++;
      conclude();
    end
  end
  initial begin
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    rd(src_pkg::CMD_OFS);
    chk("pend_boot", 32'h1, 32'(rdat[31]));
    settle();
    chk("sta_ok", 32'h1, 32'(stav));
    chk("sta_hi", 32'h1615, 32'(sta[47:32]));
    rd(src_pkg::STA_LO_OFS);
    chk("sta_lo", 32'h14131211, rdat);
    rd(src_pkg::INT_STS_OFS);
    chk("sts_boot", 32'h1, rdat);
    wr(src_pkg::INT_MASK_OFS, 32'h1);
    chk("wr_okay", {30'h0, src_pkg::RESP_OKAY}, {30'h0, rsp});
    repeat (2) @(negedge clk);
    chk("irq_on", 32'h1, 32'(irq));
    wr(src_pkg::INT_STS_OFS, 32'h1);
    repeat (2) @(negedge clk);
    chk("irq_off", 32'h0, 32'(irq));
    rd(8'hF0);
    chk("unmapped", {30'h0, src_pkg::RESP_SLVERR}, {rdat[29:0], rsp});
    wr(8'hF4, 32'h0);
    chk("wr_unmapped", {30'h0, src_pkg::RESP_SLVERR}, {30'h0, rsp});
    op(3'h3, 7'h05, 8'h3C);
    rdop(7'h05, 8'h15);
    op(3'h2, 7'h00, 8'h00);
    rd(src_pkg::CMD_OFS);
    chk("wen", 32'h1, 32'(rdat[7]));
    op(3'h3, 7'h05, 8'h3C);
    rdop(7'h05, 8'h3C);
    op(3'h5, 7'h05, 8'h00);
    rd(src_pkg::CMD_OFS);
    chk("opcode", 32'h5, 32'(rdat[30:28]));
    rdop(7'h05, 8'hFF);
    op(3'h4, 7'h00, 8'h5A);
    rdop(7'h09, 8'h5A);
    op(3'h1, 7'h00, 8'h00);
    op(3'h3, 7'h09, 8'h77);
    rdop(7'h09, 8'h5A);
    op(3'h2, 7'h00, 8'h00);
    wr(src_pkg::INT_STS_OFS, 32'h7);
    present <= 1'b0;
    t0 = cyc;
    op(3'h3, 7'h09, 8'h11);
    present <= 1'b1;
    chk("to_len", 32'h1, 32'(cyc - t0 >= TO));
    rd(src_pkg::INT_STS_OFS);
    chk("sts_to", 32'h3, rdat);
    op(3'h6, 7'h00, 8'h00);
    rdop(7'h09, 8'hFF);
    op(3'h7, 7'h00, 8'h00);
    chk("sta_gone", 32'h0, 32'(stav));
    rd(src_pkg::INT_STS_OFS);
    chk("sts_fail", 32'h4, rdat & 32'h4);
    conclude();
  end
endmodule : src_rom_ctrl_test
